// [core/buzzer_tone_gen.sv]
`include "shock_alarm_map.svh"

module buzzer_tone_gen (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  tone_link_if.tone link
);

  shock_alarm_pkg::tone_state_s s_ff;
  shock_alarm_pkg::tone_state_s nxt_s;

  // ==========================================================
  // 8-bit half-period timer
  always_comb
  begin
    nxt_s = s_ff;
    if (!link.run)
    begin
      nxt_s.cnt = 8'h00;
      nxt_s.drive = 1'b0;
    end
    else if (link.core_tick)
    begin
      if (s_ff.cnt == `BUZZ_HALF_LAST)
      begin
        nxt_s.cnt = 8'h00;
        nxt_s.drive = ~s_ff.drive;
      end
      else
      begin
        nxt_s.cnt = s_ff.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign link.drive = s_ff.drive;

endmodule

// [core/shock_alarm_controller.sv]
// Function
// - after reset, blink led 10 s, 50 ms period
// - then led off, wait in standby
// - shock in standby starts 500 ms blinking
// - buzzer timer starts same cycle as alarm blink, output low for first 250 core ticks
// - after 20 s led off, back standby
// - buzzer 50% square from separate 8-bit timer
// - own ms timer channel sets blink period
// - transmit-only serial line, no receiver
// - all timing from one 5 MHz tick
// - watchdog stays stopped after reset
`include "shock_alarm_map.svh"

module shock_alarm_controller #(
  parameter int unsigned CORE_TICKS_PER_MS = `CORE_TICKS_PER_MS,
  parameter int unsigned POWERON_MS = `POWERON_BLINK_MS,
  parameter int unsigned ALARM_MS = `ALARM_MS,
  parameter int unsigned UART_BIT_TICKS = `UART_BIT_TICKS
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic shock_irq_in_i,
  output logic led_o,
  output logic buzzer_drive_out_o,
  output logic serial_tx_line_o,
  output logic alarm_active_o,
  output logic watchdog_running_o
);

  shock_alarm_pkg::ctrl_state_s s_ff;
  shock_alarm_pkg::ctrl_state_s nxt_s;

  logic core_tick;
  logic ms_tick;
  logic shock_rise;
  logic blink_half_end;
  logic phase_end;
  logic [`BLINK_W-1:0] blink_half_last;
  logic [`PHASE_W-1:0] phase_last;

  tone_link_if link ();

  // ==========================================================
  // tick dividers
  assign core_tick = (s_ff.div_cnt == `DIV_W'(`CORE_DIV_CYCLES - 1));
  assign ms_tick = core_tick
    && (s_ff.prescale == `PRESCALE_W'(CORE_TICKS_PER_MS - 1));

  // ==========================================================
  // blink and phase limits
  always_comb
  begin
    if (s_ff.st == shock_alarm_pkg::ST_ALARM)
    begin
      blink_half_last = `BLINK_W'(`SLOW_BLINK_HALF_MS - 1);
      phase_last = `PHASE_W'(ALARM_MS - 1);
    end
    else
    begin
      blink_half_last = `BLINK_W'(`FAST_BLINK_HALF_MS - 1);
      phase_last = `PHASE_W'(POWERON_MS - 1);
    end
  end

  assign blink_half_end = ms_tick && (s_ff.blink_cnt == blink_half_last);
  assign phase_end = ms_tick && (s_ff.phase_cnt == phase_last);
  assign shock_rise = shock_irq_in_i && !s_ff.shock_prev;

  // ==========================================================
  // next state
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.shock_prev = shock_irq_in_i;
    nxt_s.wdt_run = 1'b0;

    // core divider free running, ms prescaler restarted on shock in standby
    if (core_tick)
    begin
      nxt_s.div_cnt = '0;
    end
    else
    begin
      nxt_s.div_cnt = s_ff.div_cnt + `DIV_W'(1);
    end


    if (ms_tick)
    begin
      nxt_s.prescale = '0;
    end
    else if (core_tick)
    begin
      nxt_s.prescale = s_ff.prescale + `PRESCALE_W'(1);
    end


    // ==========================================================
    // alarm phase sequencing
    case (s_ff.st)
      shock_alarm_pkg::ST_POWERON,
      shock_alarm_pkg::ST_ALARM:
      begin
        if (phase_end)
        begin
          nxt_s.st = shock_alarm_pkg::ST_STANDBY;
          nxt_s.led = 1'b0;
          nxt_s.blink_cnt = '0;
          nxt_s.phase_cnt = '0;
        end
        else if (ms_tick)
        begin
          nxt_s.phase_cnt = s_ff.phase_cnt + `PHASE_W'(1);
          if (blink_half_end)
          begin
            nxt_s.blink_cnt = '0;
            nxt_s.led = ~s_ff.led;
          end
          else
          begin
            nxt_s.blink_cnt = s_ff.blink_cnt + `BLINK_W'(1);
          end
        end
      end

      shock_alarm_pkg::ST_STANDBY:
      begin
        nxt_s.led = 1'b0;
        if (shock_rise)
        begin
          nxt_s.st = shock_alarm_pkg::ST_ALARM;
          nxt_s.led = 1'b1;
          nxt_s.blink_cnt = '0;
          nxt_s.phase_cnt = '0;
          // prescale restart aligns the first ms tick
          nxt_s.prescale = '0;
          nxt_s.tx_pend = 1'b1;
        end
      end

      default:
      begin
        nxt_s.st = shock_alarm_pkg::ST_STANDBY;
        nxt_s.led = 1'b0;
      end
    endcase


    // ==========================================================
    // serial transmit, start bit, 8 data lsb first, stop bit
    // idle, load a queued frame
    if (s_ff.tx_bits == 4'h0)
    begin
      nxt_s.tx_line = 1'b1;
      if (s_ff.tx_pend)
      begin
        nxt_s.tx_pend = 1'b0;
        nxt_s.tx_shift = {1'b1, `UART_ALARM_CODE};
        nxt_s.tx_bits = `UART_FRAME_BITS;
        nxt_s.baud_cnt = '0;
        nxt_s.tx_line = 1'b0;
      end
    end

    else if (core_tick)
    begin
      if (s_ff.baud_cnt == `BAUD_W'(UART_BIT_TICKS - 1))
      begin
        nxt_s.baud_cnt = '0;
        nxt_s.tx_bits = s_ff.tx_bits - 4'h1;
        if (s_ff.tx_bits != 4'h1)
        begin
          nxt_s.tx_line = s_ff.tx_shift[0];
          nxt_s.tx_shift = {1'b1, s_ff.tx_shift[8:1]};
        end
      end
      else
      begin
        nxt_s.baud_cnt = s_ff.baud_cnt + `BAUD_W'(1);
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      s_ff <= '0;
      s_ff.st <= shock_alarm_pkg::ST_POWERON;
      s_ff.tx_shift <= 9'h1ff;
      s_ff.tx_line <= 1'b1;
      // shock input must be seen low before a trigger
      s_ff.shock_prev <= 1'b1;
      s_ff.wdt_run <= 1'b0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================
  // buzzer tone channel
  // tone timer runs only in alarm
  assign link.core_tick = core_tick;
  assign link.run = (s_ff.st == shock_alarm_pkg::ST_ALARM);

  buzzer_tone_gen u_tone (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .link(link)
  );

  // ==========================================================
  // outputs
  assign led_o = s_ff.led;
  assign buzzer_drive_out_o = link.drive;
  assign serial_tx_line_o = s_ff.tx_line;
  assign alarm_active_o = (s_ff.st == shock_alarm_pkg::ST_ALARM);
  assign watchdog_running_o = s_ff.wdt_run;

endmodule

// [core/shock_alarm_map.svh]
`ifndef SHOCK_ALARM_MAP_SVH
`define SHOCK_ALARM_MAP_SVH

// ==========================================================
// clocks
`define SYS_CLK_HZ 100000000
`define CORE_CLK_HZ 5000000
`define CORE_DIV_CYCLES (`SYS_CLK_HZ / `CORE_CLK_HZ)
`define CORE_TICKS_PER_MS (`CORE_CLK_HZ / 1000)

// ==========================================================
// led and alarm timing
`define POWERON_BLINK_S 10
`define POWERON_BLINK_MS (`POWERON_BLINK_S * 1000)
`define FAST_BLINK_PERIOD_MS 50
`define FAST_BLINK_HALF_MS (`FAST_BLINK_PERIOD_MS / 2)
`define SLOW_BLINK_PERIOD_MS 500
`define SLOW_BLINK_HALF_MS (`SLOW_BLINK_PERIOD_MS / 2)
`define ALARM_S 20
`define ALARM_MS (`ALARM_S * 1000)

// ==========================================================
// buzzer tone, 8-bit timer in core ticks
`define BUZZ_HALF_LAST 8'hf9

// ==========================================================
// serial transmit
`define UART_BAUD 9600
`define UART_BIT_TICKS (`CORE_CLK_HZ / `UART_BAUD)
`define UART_FRAME_BITS 4'ha
`define UART_ALARM_CODE 8'h41

// ==========================================================
// state widths
`define DIV_W 5
`define PRESCALE_W 13
`define BLINK_W 9
`define PHASE_W 15
`define BAUD_W 10

`endif

// [core/shock_alarm_pkg.sv]
`include "shock_alarm_map.svh"

package shock_alarm_pkg;

  typedef enum logic [1:0] {
    ST_POWERON = 2'b00,
    ST_STANDBY = 2'b01,
    ST_ALARM = 2'b10
  } alarm_state_e;

  typedef struct packed {
    alarm_state_e st;
    logic [`DIV_W-1:0] div_cnt;
    logic [`PRESCALE_W-1:0] prescale;
    logic [`BLINK_W-1:0] blink_cnt;
    logic [`PHASE_W-1:0] phase_cnt;
    logic led;
    logic shock_prev;
    logic [8:0] tx_shift;
    logic [3:0] tx_bits;
    logic [`BAUD_W-1:0] baud_cnt;
    logic tx_line;
    logic tx_pend;
    logic wdt_run;
  } ctrl_state_s;

  typedef struct packed {
    logic [7:0] cnt;
    logic drive;
  } tone_state_s;

endpackage

// [core/tone_link_if.sv]
interface tone_link_if;
  logic core_tick;
  logic run;
  logic drive;

  modport ctrl (
    output core_tick,
    output run,
    input drive
  );

  modport tone (
    input core_tick,
    input run,
    output drive
  );
endinterface

// [testbench/shock_alarm_monitor.sv]
// ==========
// alarm output checks
module shock_alarm_monitor (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic shock_irq_in_i,
  input wire logic led_o,
  input wire logic buzzer_drive_out_o,
  input wire logic serial_tx_line_o,
  input wire logic alarm_active_o,
  input wire logic watchdog_running_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_start_bit;
    serial_tx_line_o ##1 !serial_tx_line_o;
  endsequence
  a_alarm_led_on:
  assert property ($rose(alarm_active_o) |-> led_o)
  else $error("alarm began with led off");
  a_only_shock:
  assert property ($rose(alarm_active_o) |-> $past(shock_irq_in_i) && !$past(shock_irq_in_i, 2))
  else $error("alarm without shock edge");
  a_buzz_late:
  assert property ($rose(alarm_active_o) |-> !buzzer_drive_out_o [*8])
  else $error("buzzer phase wrong at start");
  a_end_led_off:
  assert property ($fell(alarm_active_o) |-> !led_o)
  else $error("led on after alarm");
  a_buzz_quiet:
  assert property (!alarm_active_o && !$past(alarm_active_o) |-> !buzzer_drive_out_o)
  else $error("buzzer active outside alarm");
  a_buzz_hold:
  assert property (alarm_active_o && $changed(buzzer_drive_out_o) |=> $stable(buzzer_drive_out_o) [*8])
  else $error("buzzer toggled too fast");
  a_tx_start:
  assert property ($rose(alarm_active_o) |-> s_start_bit)
  else $error("no start bit after alarm");
  a_led_hold:
  assert property ($changed(led_o) |=> $stable(led_o) [*8])
  else $error("led toggled too fast");
  a_wdt_off:
  assert property (!watchdog_running_o)
  else $error("watchdog running");
endmodule

// [testbench/testbench.sv]
// ==========
// alarm sequence bench
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic shock_irq_in_i = 1'b0;
  logic led_o, buzzer_drive_out_o, serial_tx_line_o, alarm_active_o, watchdog_running_o;
  logic [7:0] rx_byte;
  int n_errors = 0;
  int checks = 0;
  int n;
  always #5 sys_clk_i = ~sys_clk_i;
  shock_alarm_controller #(.CORE_TICKS_PER_MS(4), .POWERON_MS(60), .ALARM_MS(300),
    .UART_BIT_TICKS(4)) shock_alarm_controller_inst (.sys_clk_i, .rst_n_i, .shock_irq_in_i,
    .led_o, .buzzer_drive_out_o, .serial_tx_line_o, .alarm_active_o, .watchdog_running_o);
  uart_rx_model #(.BIT_CLKS(80)) uart_rx_model_inst (.sys_clk_i, .line_i(serial_tx_line_o),
    .byte_o(rx_byte));
  task summarize;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask
  task shock;
    @(posedge sys_clk_i) shock_irq_in_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    shock_irq_in_i <= 1'b0;
  endtask
  task t_poweron;
    chk(led_o, 0);
    chk(watchdog_running_o, 0);
    chk(serial_tx_line_o, 1);
    cyc(796);
    shock();
    cyc(1600);
    chk(led_o, 1);
    chk(alarm_active_o, 0);
    cyc(2000);
    chk(led_o, 0);
    cyc(500);
    chk({led_o, alarm_active_o}, 0);
    $display("poweron test done");
  endtask
  task t_alarm;
    @(posedge sys_clk_i) shock_irq_in_i <= 1'b1;
    cyc(2);
    chk({alarm_active_o, led_o, buzzer_drive_out_o}, 3'h6);
    cyc(1);
    chk(serial_tx_line_o, 0);
    @(posedge sys_clk_i) shock_irq_in_i <= 1'b0;
    cyc(1000);
    chk(rx_byte, 8'h41);
    shock();
    cyc(4193);
    chk(buzzer_drive_out_o, 1);
    cyc(5000);
    chk(buzzer_drive_out_o, 0);
    cyc(10200);
    chk({alarm_active_o, led_o}, 2'h2);
    n = 0;
    while (alarm_active_o === 1'b1 && n < 8000)
    begin
      cyc(1);
      n++;
    end
    chk(20400 + n > 23960 && 20400 + n < 24040, 1);
    chk(led_o, 0);
    cyc(1);
    chk(buzzer_drive_out_o, 0);
    $display("alarm test done");
  endtask
  task t_rearm;
    @(posedge sys_clk_i) shock_irq_in_i <= 1'b1;
    cyc(2);
    chk(alarm_active_o, 1);
    $display("rearm test done");
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    cyc(1);
    t_poweron();
    t_alarm();
    t_rearm();
    summarize();
  end
endmodule
bind shock_alarm_controller shock_alarm_monitor shock_alarm_monitor_inst (.sys_clk_i, .rst_n_i,
  .shock_irq_in_i, .led_o, .buzzer_drive_out_o, .serial_tx_line_o, .alarm_active_o,
  .watchdog_running_o);

// [testbench/uart_rx_model.sv]
// ==========
// serial receiver
module uart_rx_model #(
  parameter int BIT_CLKS = 80
) (
  input wire logic sys_clk_i,
  input wire logic line_i,
  output logic [7:0] byte_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial byte_o = 8'h00;
  // samples mid bit, lsb first
  always @(negedge line_i)
  begin
    repeat (BIT_CLKS + BIT_CLKS / 2) @(posedge sys_clk_i);
    for (int i = 0; i < 8; i++)
    begin
      byte_o[i] <= line_i;
      repeat (BIT_CLKS) @(posedge sys_clk_i);
    end
  end
endmodule
